/* File: hdl/pixel_delay_line.sv */
// Fixed-depth register pipeline
`timescale 1ns/10ps
module pixel_delay_line #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 11
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  if (DEPTH < 1 || WIDTH < 1) begin : gen_check
    $error("pixel_delay_line needs DEPTH and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] stage_ff [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : gen_stage
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        stage_ff[i] <= '0;
      end else if (i == 0) begin
        stage_ff[i] <= dataIn;
      end else begin
        stage_ff[i] <= stage_ff[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign dataOut = stage_ff[DEPTH-1];

endmodule

/* File: hdl/pixel_port_pkg.sv */
// Package with register map, pixel formats and decode functions
package pixel_port_pkg;

  localparam int PIPE_LATENCY = 12;

  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PRI = 8'h04;
  localparam logic [7:0] OFF_SEC = 8'h08;
  localparam logic [7:0] OFF_PLL = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;

  localparam int CMD_EXT_BIT = 3;
  localparam int CMD_SVGA_LSB = 5;
  localparam int PLL_W = 2;

  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] PRI_RESET = 8'h00;
  localparam logic [7:0] SEC_RESET = 8'h00;
  localparam logic [1:0] PLL_RESET = 2'h2;

  localparam logic [7:0] MODE_IDX8 = 8'h00;
  localparam logic [7:0] MODE_MIX15 = 8'h01;
  localparam logic [7:0] MODE_X15 = 8'h02;
  localparam logic [7:0] MODE_X16 = 8'h03;
  localparam logic [7:0] MODE_X24 = 8'h04;
  localparam logic [7:0] MODE_DBL = 8'h05;

  localparam logic [2:0] SVGA_IDX8 = 3'h0;
  localparam logic [2:0] SVGA_15 = 3'h5;
  localparam logic [2:0] SVGA_16 = 3'h6;
  localparam logic [2:0] SVGA_24 = 3'h7;

  typedef enum logic [3:0] {
    FMT_IDX8, FMT_S15, FMT_S16, FMT_S24, FMT_X15I, FMT_X15, FMT_X16, FMT_X24, FMT_DBL
  } fmt_t;

  // Extended mode code to format, reserved codes fall back to indexed
  function automatic fmt_t extFmt(input logic [7:0] code);
    fmt_t f;
    f = FMT_IDX8;
    case (code)
      MODE_MIX15: f = FMT_X15I;
      MODE_X15: f = FMT_X15;
      MODE_X16: f = FMT_X16;
      MODE_X24: f = FMT_X24;
      MODE_DBL: f = FMT_DBL;
      default: f = FMT_IDX8;
    endcase
    return f;
  endfunction

  // Standard mode field to format, reserved codes fall back to indexed
  function automatic fmt_t svgaFmt(input logic [2:0] code);
    fmt_t f;
    f = FMT_IDX8;
    case (code)
      SVGA_15: f = FMT_S15;
      SVGA_16: f = FMT_S16;
      SVGA_24: f = FMT_S24;
      default: f = FMT_IDX8;
    endcase
    return f;
  endfunction

  // Bus words per pixel, minus one
  function automatic logic [1:0] lastIdx(input fmt_t f);
    logic [1:0] n;
    n = 2'h0;
    case (f)
      FMT_S15, FMT_S16, FMT_X24: n = 2'h1;
      FMT_S24: n = 2'h2;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

endpackage

/* File: hdl/pixel_port_unpacker.sv */
// Pixel port unpacker with APB register slave
`timescale 1ns/10ps
module pixel_port_unpacker #(
  parameter int LATENCY = pixel_port_pkg::PIPE_LATENCY
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pixelBus,
  input wire logic videoBlankLow,
  input wire logic modeMixSelect,
  output logic pixelStrobe,
  output logic videoOn,
  output logic pixelIndexed,
  output logic dualPixel,
  output logic [7:0] indexFirst,
  output logic [7:0] indexSecond,
  output logic [7:0] red,
  output logic [7:0] green,
  output logic [7:0] blue,
  output logic [1:0] pllRange
);

  if (LATENCY < 2) begin : gen_check
    $error("LATENCY must be at least 2");
  end

  localparam int PIPE_DEPTH = LATENCY - 1;
  localparam int PAYLOAD_W = 44;

  logic [7:0] pixCmd_ff;
  logic [7:0] priMode_ff;
  logic [7:0] secMode_ff;
  logic [1:0] pllRange_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic setupPhase;
  logic wrAccess;

  logic [15:0] inWord_ff;
  logic inBlank_ff;
  logic inMix_ff;
  logic prevBlank_ff;
  logic [1:0] wordCnt_ff;
  pixel_port_pkg::fmt_t curFmt_ff;
  logic [15:0] word0_ff;
  logic [7:0] word1_ff;

  logic asmValid_ff;
  logic asmOn_ff;
  logic asmIndex_ff;
  logic asmDual_ff;
  logic [7:0] asmIdx0_ff;
  logic [7:0] asmIdx1_ff;
  logic [7:0] asmRed_ff;
  logic [7:0] asmGreen_ff;
  logic [7:0] asmBlue_ff;
  pixel_port_pkg::fmt_t asmFmt_ff;

  logic blankRise;
  logic extEn;
  logic firstWord;
  logic lastWord;
  logic [1:0] wordIdx;
  pixel_port_pkg::fmt_t selFmt;
  pixel_port_pkg::fmt_t fmtNow;
  logic decIndex;
  logic decDual;
  logic [7:0] decIdx0;
  logic [7:0] decIdx1;
  logic [7:0] decRed;
  logic [7:0] decGreen;
  logic [7:0] decBlue;
  logic [PAYLOAD_W-1:0] pipeIn;
  logic [PAYLOAD_W-1:0] pipeOut;

  // APB slave, zero-wait access phase
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pwrite;
  assign pready = psel && penable;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pllRange = pllRange_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pixCmd_ff <= pixel_port_pkg::CMD_RESET;
    end else if (wrAccess && paddr == pixel_port_pkg::OFF_CMD) begin
      pixCmd_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      priMode_ff <= pixel_port_pkg::PRI_RESET;
      secMode_ff <= pixel_port_pkg::SEC_RESET;
    end else if (wrAccess && paddr == pixel_port_pkg::OFF_PRI) begin
      priMode_ff <= pwdata[7:0];
    end else if (wrAccess && paddr == pixel_port_pkg::OFF_SEC) begin
      secMode_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pllRange_ff <= pixel_port_pkg::PLL_RESET;
    end else if (wrAccess && paddr == pixel_port_pkg::OFF_PLL) begin
      pllRange_ff <= pwdata[pixel_port_pkg::PLL_W-1:0];
    end
  end

  // Read mux, unmapped addresses answer zero with error
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr)
      pixel_port_pkg::OFF_CMD: nxt_prdata[7:0] = pixCmd_ff;
      pixel_port_pkg::OFF_PRI: nxt_prdata[7:0] = priMode_ff;
      pixel_port_pkg::OFF_SEC: nxt_prdata[7:0] = secMode_ff;
      pixel_port_pkg::OFF_PLL: nxt_prdata[1:0] = pllRange_ff;
      pixel_port_pkg::OFF_STAT: nxt_prdata[7:0] = {inMix_ff, wordCnt_ff, 1'b0, curFmt_ff};
      default: nxt_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setupPhase) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Bus, blank and mix sampled on the same edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      inWord_ff <= 16'h0000;
      inBlank_ff <= 1'b0;
      inMix_ff <= 1'b0;
      prevBlank_ff <= 1'b0;
    end else begin
      inWord_ff <= pixelBus;
      inBlank_ff <= videoBlankLow;
      inMix_ff <= modeMixSelect;
      prevBlank_ff <= inBlank_ff;
    end
  end

  assign blankRise = inBlank_ff && !prevBlank_ff;
  assign extEn = pixCmd_ff[pixel_port_pkg::CMD_EXT_BIT];

  // Format chosen from command field or mix between primary and secondary
  always_comb begin
    if (!extEn) begin
      selFmt = pixel_port_pkg::svgaFmt(pixCmd_ff[7:pixel_port_pkg::CMD_SVGA_LSB]);
    end else if (inMix_ff) begin
      selFmt = pixel_port_pkg::extFmt(secMode_ff);
    end else begin
      selFmt = pixel_port_pkg::extFmt(priMode_ff);
    end
  end

  // Word position within pixel, realigned by blank release
  assign firstWord = blankRise || (wordCnt_ff == 2'h0);
  assign wordIdx = firstWord ? 2'h0 : wordCnt_ff;
  assign fmtNow = firstWord ? selFmt : curFmt_ff;
  assign lastWord = (wordIdx == pixel_port_pkg::lastIdx(fmtNow));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wordCnt_ff <= 2'h0;
    end else if (!inBlank_ff || lastWord) begin
      wordCnt_ff <= 2'h0;
    end else begin
      wordCnt_ff <= wordIdx + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      curFmt_ff <= pixel_port_pkg::FMT_IDX8;
    end else begin
      curFmt_ff <= fmtNow;
    end
  end

  // Lower-order words held until the pixel completes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      word0_ff <= 16'h0000;
      word1_ff <= 8'h00;
    end else begin
      if (wordIdx == 2'h0) begin
        word0_ff <= inWord_ff;
      end
      if (wordIdx == 2'h1) begin
        word1_ff <= inWord_ff[7:0];
      end
    end
  end

  pixel_word_decode u_decode (
    .fmt(fmtNow),
    .word(inWord_ff),
    .word0(word0_ff),
    .word1(word1_ff),
    .isIndex(decIndex),
    .dual(decDual),
    .idx0(decIdx0),
    .idx1(decIdx1),
    .red(decRed),
    .green(decGreen),
    .blue(decBlue)
  );

  // Assembled pixel stage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      asmValid_ff <= 1'b0;
      asmOn_ff <= 1'b0;
    end else begin
      asmValid_ff <= inBlank_ff && lastWord;
      asmOn_ff <= inBlank_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      asmIndex_ff <= 1'b0;
      asmDual_ff <= 1'b0;
      asmIdx0_ff <= 8'h00;
      asmIdx1_ff <= 8'h00;
      asmRed_ff <= 8'h00;
      asmGreen_ff <= 8'h00;
      asmBlue_ff <= 8'h00;
      asmFmt_ff <= pixel_port_pkg::FMT_IDX8;
    end else if (lastWord) begin
      asmIndex_ff <= decIndex;
      asmDual_ff <= decDual;
      asmIdx0_ff <= decIdx0;
      asmIdx1_ff <= decIdx1;
      asmRed_ff <= decRed;
      asmGreen_ff <= decGreen;
      asmBlue_ff <= decBlue;
      asmFmt_ff <= fmtNow;
    end
  end

  // Pipe gives the fixed latency in every mode, blanked payload enters as zero
  assign pipeIn = {asmValid_ff, asmOn_ff, asmOn_ff && asmIndex_ff, asmOn_ff && asmDual_ff,
                   asmOn_ff ? {asmIdx0_ff, asmIdx1_ff, asmRed_ff, asmGreen_ff, asmBlue_ff}
                            : 40'h00_0000_0000};

  pixel_delay_line #(
    .WIDTH(PAYLOAD_W),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .ref_clk(ref_clk),
    .reset(reset),
    .dataIn(pipeIn),
    .dataOut(pipeOut)
  );

  // Outputs taken straight from the last pipe stage
  always_comb begin
    pixelStrobe = pipeOut[43];
    videoOn = pipeOut[42];
    pixelIndexed = pipeOut[41];
    dualPixel = pipeOut[40];
    indexFirst = pipeOut[39:32];
    indexSecond = pipeOut[31:24];
    red = pipeOut[23:16];
    green = pipeOut[15:8];
    blue = pipeOut[7:0];
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  latency_twelve_a: assert property (
    asmValid_ff |-> ##PIPE_DEPTH pixelStrobe
  ) else $error("pixel strobe missing after pipeline latency");

  strobe_cause_a: assert property (
    pixelStrobe |-> $past(asmValid_ff, PIPE_DEPTH)
  ) else $error("pixel strobe without assembled pixel");

  blank_off_a: assert property (
    (!asmOn_ff) |-> ##PIPE_DEPTH (!videoOn && red == 8'h00 && indexFirst == 8'h00)
  ) else $error("outputs not off after blanked word");

  realign_first_a: assert property (
    blankRise && pixel_port_pkg::lastIdx(selFmt) != 2'h0 |=> wordCnt_ff == 2'h1
  ) else $error("blank release did not start a new pixel");

  zero_fill_a: assert property (
    asmValid_ff && asmFmt_ff == pixel_port_pkg::FMT_S15 |-> asmRed_ff[2:0] == 3'h0
      && asmGreen_ff[2:0] == 3'h0 && asmBlue_ff[2:0] == 3'h0
  ) else $error("unspecified colour bits not zero");

  mix_select_a: assert property (
    extEn && firstWord && !inMix_ff |-> fmtNow == pixel_port_pkg::extFmt(priMode_ff)
  ) else $error("mix low did not select primary format");

  boundary_hold_a: assert property (
    inBlank_ff && wordCnt_ff != 2'h0 && !blankRise |-> fmtNow == $past(fmtNow)
  ) else $error("format changed inside a pixel");

  dual_order_a: assert property (
    asmValid_ff && asmFmt_ff == pixel_port_pkg::FMT_DBL |->
      asmIdx0_ff == $past(inWord_ff[7:0]) && asmIdx1_ff == $past(inWord_ff[15:8])
  ) else $error("double pixel order wrong");

  two_word_a: assert property (
    asmValid_ff && asmFmt_ff == pixel_port_pkg::FMT_X24 |->
      asmRed_ff == $past(inWord_ff[7:0]) && asmGreen_ff == $past(word0_ff[15:8], 1)
  ) else $error("two-word pixel assembled wrongly");

  ext_gate_a: assert property (
    !extEn && firstWord |-> fmtNow == pixel_port_pkg::svgaFmt(pixCmd_ff[7:5])
  ) else $error("extended format used while disabled");

  dual_pixel_c: cover property (asmValid_ff && asmFmt_ff == pixel_port_pkg::FMT_DBL);
  svga_true_c: cover property (asmValid_ff && asmFmt_ff == pixel_port_pkg::FMT_S24);
  mix_switch_c: cover property (extEn && firstWord && inMix_ff && $past(!inMix_ff));
  blank_rise_c: cover property (blankRise ##1 !blankRise [*2] ##1 asmValid_ff);

endmodule

/* File: hdl/pixel_word_decode.sv */
// Combinational unpacking of bus words into one pixel, or two indexed pixels in double mode
`timescale 1ns/10ps
module pixel_word_decode (
  input wire pixel_port_pkg::fmt_t fmt,
  input wire logic [15:0] word,
  input wire logic [15:0] word0,
  input wire logic [7:0] word1,
  output logic isIndex,
  output logic dual,
  output logic [7:0] idx0,
  output logic [7:0] idx1,
  output logic [7:0] red,
  output logic [7:0] green,
  output logic [7:0] blue
);

  always_comb begin
    isIndex = 1'b0;
    dual = 1'b0;
    idx0 = 8'h00;
    idx1 = 8'h00;
    // Bits not carried by a format stay zero
    red = 8'h00;
    green = 8'h00;
    blue = 8'h00;
    unique case (fmt)
      pixel_port_pkg::FMT_IDX8: begin
        isIndex = 1'b1;
        idx0 = word[7:0];
      end
      pixel_port_pkg::FMT_S15: begin
        blue[7:3] = word0[4:0];
        green[5:3] = word0[7:5];
        green[7:6] = word[1:0];
        red[7:3] = word[6:2];
      end
      pixel_port_pkg::FMT_S16: begin
        blue[7:3] = word0[4:0];
        green[4:2] = word0[7:5];
        green[7:5] = word[2:0];
        red[7:3] = word[7:3];
      end
      pixel_port_pkg::FMT_S24: begin
        blue = word0[7:0];
        green = word1;
        red = word[7:0];
      end
      pixel_port_pkg::FMT_X15I: begin
        if (!word[15]) begin
          isIndex = 1'b1;
          idx0 = word[7:0];
        end else begin
          red[7:3] = word[14:10];
          green[7:3] = word[9:5];
          blue[7:3] = word[4:0];
        end
      end
      pixel_port_pkg::FMT_X15: begin
        red[7:3] = word[14:10];
        green[7:3] = word[9:5];
        blue[7:3] = word[4:0];
      end
      pixel_port_pkg::FMT_X16: begin
        red[7:3] = word[15:11];
        green[7:2] = word[10:5];
        blue[7:3] = word[4:0];
      end
      pixel_port_pkg::FMT_X24: begin
        green = word0[15:8];
        blue = word0[7:0];
        red = word[7:0];
      end
      pixel_port_pkg::FMT_DBL: begin
        isIndex = 1'b1;
        dual = 1'b1;
        idx0 = word[7:0];
        idx1 = word[15:8];
      end
    endcase
  end

endmodule

/* File: sim/pixel_source_model.sv */
// Graphics controller model driving the pixel port
`timescale 1ns/10ps
module pixel_source_model (
  input wire logic ref_clk,
  output logic [15:0] pixelBus,
  output logic videoBlankLow,
  output logic modeMixSelect
);
  logic [17:0] q[$];
  logic [17:0] e;
  int popCyc[$];
  int cyc = 0;

  initial begin
    pixelBus = 16'h0000;
    videoBlankLow = 1'b0;
    modeMixSelect = 1'b0;
  end

  always @(negedge ref_clk) begin
    cyc++;
  end

  // One queued entry per edge, in queue order
  always @(posedge ref_clk) begin
    e = 18'h00000;
    if (q.size() > 0) begin
      e = q.pop_front();
      popCyc.push_back(cyc);
    end
    if (e[17]) begin
      pixelBus <= e[15:0];
      modeMixSelect <= e[16];
      videoBlankLow <= 1'b1;
    end else begin
      // Idle lines toggle so stale words never look valid
      pixelBus <= ~pixelBus;
      modeMixSelect <= ~modeMixSelect;
      videoBlankLow <= 1'b0;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the pixel port unpacker
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, indexFirst, indexSecond, red, green, blue;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pixelBus, a, b;
  logic videoBlankLow, modeMixSelect, pixelStrobe, videoOn, pixelIndexed, dualPixel;
  logic [1:0] pllRange;
  logic [57:0] seenQ[$];
  logic [41:0] expF[$];
  int expK[$];
  int nW = 0;
  int errCount = 0;
  int checks = 0;
  // Stand-in for the PLL settling time, in pixel clocks
  localparam int PLL_SETTLE_CYC = 200;

  pixel_port_unpacker #(.LATENCY(pixel_port_pkg::PIPE_LATENCY)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixelBus(pixelBus), .videoBlankLow(videoBlankLow), .modeMixSelect(modeMixSelect),
    .pixelStrobe(pixelStrobe), .videoOn(videoOn), .pixelIndexed(pixelIndexed),
    .dualPixel(dualPixel), .indexFirst(indexFirst), .indexSecond(indexSecond),
    .red(red), .green(green), .blue(blue), .pllRange(pllRange)
  );

  pixel_source_model src_u (
    .ref_clk(ref_clk), .pixelBus(pixelBus), .videoBlankLow(videoBlankLow),
    .modeMixSelect(modeMixSelect)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (pixelStrobe === 1'b1) begin
      seenQ.push_back({16'(src_u.cyc), pixelIndexed, dualPixel, indexFirst, indexSecond,
        red, green, blue});
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(logic [63:0] g, logic [63:0] x);
    checks++;
    if (g !== x) begin
      errCount++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask

  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
      report_and_stop();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic mode(logic [7:0] p, logic [7:0] s);
    apb(1'b1, pixel_port_pkg::OFF_PRI, 32'(p));
    apb(1'b1, pixel_port_pkg::OFF_SEC, 32'(s));
  endtask

  function automatic logic [41:0] col(logic [7:0] r, logic [7:0] g, logic [7:0] bl);
    return {18'h00000, r, g, bl};
  endfunction

  function automatic logic [41:0] idx(logic [7:0] i);
    return {2'b10, i, 32'h00000000};
  endfunction

  function automatic logic [41:0] c5(logic [15:0] w);
    return col({w[14:10], 3'h0}, {w[9:5], 3'h0}, {w[4:0], 3'h0});
  endfunction

  task automatic sw(logic bk, logic m, logic [15:0] w);
    src_u.q.push_back({bk, m, w});
    nW++;
  endtask

  task automatic px(logic [41:0] f);
    expK.push_back(nW - 1);
    expF.push_back(f);
  endtask

  task automatic run();
    int n;
    logic [57:0] m, x;
    n = 0;
    while ((src_u.q.size() > 0 || seenQ.size() < expF.size()) && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      errCount++;
      report_and_stop();
    end else begin
      repeat (16) @(posedge ref_clk);
      chk(64'(seenQ.size()), 64'(expF.size()));
      for (int i = 0; i < expF.size() && i < seenQ.size(); i++) begin
        x = {16'(src_u.popCyc[expK[i]] + 14), expF[i]};
        m = expF[i][41] ? {26'h3FFFFFF, {8{expF[i][40]}}, 24'h0} : {18'h3FFFF, 40'hFFFFFF};
        chk(64'(seenQ[i] & m), 64'(x & m));
      end
    end
    seenQ.delete();
    expF.delete();
    expK.delete();
  endtask

  task automatic regsTest();
    apb(1'b0, pixel_port_pkg::OFF_CMD, 32'h0);
    chk(64'(rd), 64'h0);
    apb(1'b0, pixel_port_pkg::OFF_PLL, 32'h0);
    chk(64'({pllRange, rd}), 64'h2_0000_0002);
    apb(1'b1, 8'h14, 32'hFF);
    chk(64'(er), 64'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(64'({er, rd}), 64'h1_0000_0000);
    apb(1'b1, pixel_port_pkg::OFF_STAT, 32'hFF);
    chk(64'(er), 64'h0);
    mode(8'h03, 8'h00);
    apb(1'b0, pixel_port_pkg::OFF_PRI, 32'h0);
    chk(64'(rd), 64'h3);
  endtask

  task automatic svgaTest();
    mode(8'h00, 8'h00);
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'h0);
    sw(1, 0, 16'hAB5C);
    px(idx(8'h5C));
    run();
    a = 16'h12E7;
    b = 16'h3456;
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'({pixel_port_pkg::SVGA_15, 5'h00}));
    sw(1, 0, a);
    sw(1, 0, b);
    px(col({b[6:2], 3'h0}, {b[1:0], a[7:5], 3'h0}, {a[4:0], 3'h0}));
    run();
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'({pixel_port_pkg::SVGA_16, 5'h00}));
    sw(1, 0, a);
    sw(1, 0, b);
    px(col({b[7:3], 3'h0}, {b[2:0], a[7:5], 2'h0}, {a[4:0], 3'h0}));
    run();
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'({pixel_port_pkg::SVGA_24, 5'h00}));
    sw(1, 0, 16'hFF11);
    sw(1, 0, 16'hEE22);
    sw(1, 0, 16'hDD33);
    px(col(8'h33, 8'h22, 8'h11));
    run();
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'h20);
    sw(1, 0, 16'h4D96);
    px(idx(8'h96));
    run();
  endtask

  task automatic extTest();
    a = 16'hD6B5;
    apb(1'b1, pixel_port_pkg::OFF_CMD, 32'h08);
    mode(8'h00, 8'h00);
    sw(1, 0, 16'hFF3C);
    px(idx(8'h3C));
    run();
    mode(8'h01, 8'h01);
    sw(1, 0, 16'h7F12);
    px(idx(8'h12));
    sw(1, 0, a);
    px(c5(a));
    run();
    mode(8'h02, 8'h02);
    sw(1, 0, a);
    px(c5(a));
    sw(1, 0, a & 16'h7FFF);
    px(c5(a));
    run();
    mode(8'h03, 8'h03);
    sw(1, 0, 16'hA5C3);
    px(col({5'h14, 3'h0}, {6'h2E, 2'h0}, {5'h03, 3'h0}));
    run();
    mode(8'h04, 8'h04);
    sw(1, 0, 16'h9A3C);
    sw(1, 0, 16'hEE71);
    px(col(8'h71, 8'h9A, 8'h3C));
    run();
    mode(8'h06, 8'h06);
    sw(1, 0, 16'h1234);
    px(idx(8'h34));
    run();
  endtask

  task automatic mixTest();
    mode(8'h03, 8'h00);
    sw(1, 0, 16'hA5C3);
    px(col(8'hA0, 8'hB8, 8'h18));
    sw(1, 1, 16'h0077);
    px(idx(8'h77));
    sw(1, 0, 16'hA5C3);
    px(col(8'hA0, 8'hB8, 8'h18));
    run();
    mode(8'h04, 8'h00);
    sw(1, 0, 16'h9A3C);
    sw(1, 0, 16'hEE71);
    px(col(8'h71, 8'h9A, 8'h3C));
    sw(1, 1, 16'h0011);
    px(idx(8'h11));
    sw(1, 1, 16'h0022);
    px(idx(8'h22));
    run();
  endtask

  task automatic dblTest();
    apb(1'b1, pixel_port_pkg::OFF_PRI, 32'h05);
    apb(1'b1, pixel_port_pkg::OFF_PLL, 32'h1);
    repeat (PLL_SETTLE_CYC) @(posedge ref_clk);
    apb(1'b1, pixel_port_pkg::OFF_SEC, 32'h05);
    apb(1'b0, pixel_port_pkg::OFF_PLL, 32'h0);
    chk(64'({pllRange, rd}), 64'h1_0000_0001);
    sw(1, 0, 16'hC3A5);
    px({2'b11, 16'hA5C3, 24'h0});
    sw(1, 1, 16'h0F1E);
    px({2'b11, 16'h1E0F, 24'h0});
    run();
    apb(1'b1, pixel_port_pkg::OFF_PLL, 32'h2);
    repeat (PLL_SETTLE_CYC) @(posedge ref_clk);
    apb(1'b0, pixel_port_pkg::OFF_PLL, 32'h0);
    chk(64'({pllRange, rd}), 64'h2_0000_0002);
  endtask

  task automatic blankTest();
    mode(8'h04, 8'h04);
    sw(1, 0, 16'h1111);
    sw(0, 0, 16'h0000);
    sw(0, 0, 16'h0000);
    sw(1, 0, 16'h9A3C);
    sw(1, 0, 16'hEE71);
    px(col(8'h71, 8'h9A, 8'h3C));
    run();
    chk(64'({videoOn, pixelIndexed, red, green, blue, indexFirst}), 64'h0);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    regsTest();
    svgaTest();
    extTest();
    mixTest();
    dblTest();
    blankTest();
    report_and_stop();
  end
endmodule
